//--- rtl/sdseq_top.sv
// What this block does
// - Cycle interval from timing register bits 13:4
// - Normal mode: each interval count is 2 us
// - Stretched mode: counts are 100 us slow ticks
// - Stretched: interval runs from one discharge start to the next, discharge included
// - Normal: interval holds discharge then recharge, 30 percent
// - Flag overflow when interval near discharge time
// - Sample is 2, 4 or 8 cycles
// - Average count one gives one ratio sample
// - Sequence averages average-count samples into result
// - Sequence adds dummy and gain compensation cycles
// - Sequence runs 2 + average count times sample cycles
// - Result is signed 24-bit, 0x800001 to 0x7FFFFF
// - One result step is 10 nV/V
// - Fast clock from resonator or internal RC
// - Stretch 2 or 3 spaces pair 200/300 us
// - Topology 1 is full, 3 is quattro
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module sdseq_top
    import sdseq_pkg::*;
#(
    parameter int unsigned PAIR2_CYCLES = PAIR2_CYC,
    parameter int unsigned PAIR3_CYCLES = PAIR3_CYC,
    parameter int unsigned TW = 24
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic discharge_done_pin,
    input wire logic slow_osc_pin,
    output logic discharge_en,
    output logic recharge_en,
    output logic [2:0] gauge_sel,
    output logic fast_osc_en,
    output logic rc_osc_sel
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and state
    logic run_q;
    logic [31:0] cfg_timing_q;
    logic [31:0] cfg_bridge_q;
    logic ovf_q;
    logic ready_q;
    logic [23:0] bridge_result_word_q;
    logic [TW-1:0] comp_q;
    logic [31:0] prdata_q;
    sdseq_state_t state_q;
    sdseq_state_t state_d;
    sdseq_phase_t phase_q;
    logic [3:0] sub_q;
    logic [15:0] smp_q;
    logic [TW-1:0] fast_q;
    logic [TW-1:0] unit_q;
    logic [5:0] unit_div_q;
    logic signed [31:0] acc_q;
    logic [2:0] done_sync_q;
    logic [2:0] slow_sync_q;

    ////////////////////////////////////////////////////////////////////////
    // Field decode
    logic [9:0] interval;
    logic [15:0] avg_cnt;
    logic [15:0] avg_eff;
    logic single_conv;
    logic [1:0] bridge;
    logic [1:0] stretch;
    logic stretched;
    logic [3:0] cps;
    assign interval = cfg_timing_q[INTERVAL_MSB:INTERVAL_LSB];
    assign avg_cnt = cfg_timing_q[AVG_MSB:AVG_LSB];
    assign avg_eff = (avg_cnt == 16'h0000) ? 16'h0001 : avg_cnt;
    assign single_conv = cfg_timing_q[SINGLE_BIT];
    assign bridge = cfg_bridge_q[BRIDGE_MSB:BRIDGE_LSB];
    assign stretch = cfg_bridge_q[STRETCH_MSB:STRETCH_LSB];
    assign stretched = (stretch != 2'h0);
    assign rc_osc_sel = cfg_bridge_q[CLKSRC_BIT];
    assign cps = (bridge == BRIDGE_HALF) ? CPS_HALF :
                 (bridge == BRIDGE_QUATTRO) ? CPS_QUATTRO : CPS_FULL;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic done_lvl;
    logic done_rise;
    logic slow_edge;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            done_sync_q <= 3'h0;
            slow_sync_q <= 3'h0;
        end else begin
            done_sync_q <= {done_sync_q[1:0], discharge_done_pin};
            slow_sync_q <= {slow_sync_q[1:0], slow_osc_pin};
        end
    end
    assign done_lvl = done_sync_q[1];
    assign done_rise = done_sync_q[1] && !done_sync_q[2];
    assign slow_edge = slow_sync_q[1] && !slow_sync_q[2];

    ////////////////////////////////////////////////////////////////////////
    // Interval timing
    logic fast_unit;
    logic unit_tick;
    logic unit_last;
    logic pair_first;
    logic pair_short;
    logic [TW-1:0] pair_cyc;
    logic [TW-1:0] unit_x10;
    logic [TW-1:0] int_x7;
    logic period_end;
    logic disch_limit;
    logic in_cycle;
    assign fast_unit = (unit_div_q == 6'(UNIT_CYC - 1));
    assign unit_tick = stretched ? slow_edge : fast_unit;
    // End on the closing tick so a period is exactly interval units
    assign unit_last = unit_tick && ((unit_q + TW'(1)) >= TW'(interval));
    assign pair_first = !sub_q[0] && (phase_q == SDSEQ_PH_SAMPLE);
    assign pair_short = stretch[1] && pair_first;
    assign pair_cyc = stretch[0] ? TW'(PAIR3_CYCLES) : TW'(PAIR2_CYCLES);
    assign unit_x10 = TW'(unit_q * 10);
    assign int_x7 = TW'(interval * (100 - RECHARGE_PCT) / 10);
    assign period_end = pair_short ? ((fast_q + TW'(1)) >= pair_cyc) :
                        ((unit_q >= TW'(interval)) || unit_last);
    // Discharge must leave room for recharge in normal mode
    assign disch_limit = stretched ? period_end : (unit_x10 >= int_x7);
    assign in_cycle = (state_q == SDSEQ_DISCH) || (state_q == SDSEQ_GAP);
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            fast_q <= '0;
            unit_q <= '0;
            unit_div_q <= '0;
        end else if (!in_cycle || (state_q == SDSEQ_GAP && period_end)) begin
            fast_q <= '0;
            unit_q <= '0;
            unit_div_q <= '0;
        end else begin
            fast_q <= fast_q + TW'(1);
            unit_div_q <= fast_unit ? 6'h00 : unit_div_q + 6'h01;
            if (unit_tick) begin
                unit_q <= unit_q + TW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    logic seq_start;
    logic disch_end;
    logic last_cycle;
    logic div_done;
    logic signed [31:0] div_quo;
    logic signed [31:0] sample_val;
    assign seq_start = (state_q == SDSEQ_IDLE) && run_q;
    assign disch_end = (state_q == SDSEQ_DISCH) && (done_lvl || done_rise || disch_limit);
    assign last_cycle = (phase_q == SDSEQ_PH_SAMPLE) && (sub_q == cps - 4'h1) &&
                        (smp_q == avg_eff - 16'h0001);
    // Alternate gauges subtract to form the ratio
    assign sample_val = sub_q[0] ? -$signed(32'(fast_q)) : $signed(32'(fast_q));
    always_comb begin
        state_d = state_q;
        case (state_q)
            SDSEQ_IDLE: begin
                if (run_q) begin
                    state_d = SDSEQ_DISCH;
                end
            end
            SDSEQ_DISCH: begin
                if (disch_end) begin
                    state_d = SDSEQ_GAP;
                end
            end
            SDSEQ_GAP: begin
                if (period_end) begin
                    state_d = last_cycle ? SDSEQ_DIV : SDSEQ_DISCH;
                end
            end
            SDSEQ_DIV: begin
                if (div_done) begin
                    state_d = SDSEQ_DONE;
                end
            end
            SDSEQ_DONE: state_d = SDSEQ_IDLE;
            default: state_d = SDSEQ_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q <= SDSEQ_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            phase_q <= SDSEQ_PH_DUMMY;
            sub_q <= 4'h0;
            smp_q <= 16'h0000;
        end else if (seq_start) begin
            phase_q <= SDSEQ_PH_DUMMY;
            sub_q <= 4'h0;
            smp_q <= 16'h0000;
        end else if (state_q == SDSEQ_GAP && period_end) begin
            if (phase_q == SDSEQ_PH_DUMMY) begin
                phase_q <= SDSEQ_PH_COMP;
            end else if (phase_q == SDSEQ_PH_COMP) begin
                phase_q <= SDSEQ_PH_SAMPLE;
            end else if (sub_q == cps - 4'h1) begin
                sub_q <= 4'h0;
                smp_q <= smp_q + 16'h0001;
            end else begin
                sub_q <= sub_q + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            acc_q <= '0;
            comp_q <= '0;
        end else if (seq_start) begin
            acc_q <= '0;
        end else if (disch_end && phase_q == SDSEQ_PH_SAMPLE) begin
            acc_q <= acc_q + sample_val;
        end else if (disch_end && phase_q == SDSEQ_PH_COMP) begin
            comp_q <= fast_q;
        end
    end

    sdseq_divider #(
        .DW(32),
        .VW(16)
    ) i_sdseq_divider (
        .core_clk(core_clk),
        .reset(reset),
        .start((state_q == SDSEQ_GAP) && period_end && last_cycle),
        .dividend(acc_q),
        .divisor(avg_eff),
        .done(div_done),
        .quotient(div_quo)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin drive
    assign discharge_en = (state_q == SDSEQ_DISCH);
    assign recharge_en = (state_q == SDSEQ_GAP) && !pair_short;
    assign gauge_sel = sub_q[2:0];
    assign fast_osc_en = !stretched ? (run_q || state_q != SDSEQ_IDLE) :
                         (state_q == SDSEQ_DISCH) || (state_q == SDSEQ_GAP && pair_short);

    ////////////////////////////////////////////////////////////////////////
    // APB slave
    logic setup;
    logic access;
    logic wr_en;
    logic rd_result;
    logic hit;
    logic [31:0] rd_mux;
    logic [31:0] status;
    logic signed [31:0] sat_val;
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_en = access && pwrite;
    assign rd_result = access && !pwrite && (paddr == ADDR_RESULT);
    assign hit = (paddr == ADDR_CTRL) || (paddr == ADDR_CFG_TIMING) ||
                 (paddr == ADDR_CFG_BRIDGE) || (paddr == ADDR_STATUS) ||
                 (paddr == ADDR_RESULT) || (paddr == ADDR_COMP);
    assign pready = 1'b1;
    assign pslverr = access && !hit;
    assign prdata = prdata_q;
    assign status = {29'h0, (state_q != SDSEQ_IDLE), ready_q, ovf_q};
    assign rd_mux = (paddr == ADDR_CTRL) ? {31'h0, run_q} :
                    (paddr == ADDR_CFG_TIMING) ? cfg_timing_q :
                    (paddr == ADDR_CFG_BRIDGE) ? cfg_bridge_q :
                    (paddr == ADDR_STATUS) ? status :
                    (paddr == ADDR_RESULT) ? {{8{bridge_result_word_q[23]}},
                                              bridge_result_word_q} :
                    (paddr == ADDR_COMP) ? 32'(comp_q) : 32'h0000_0000;
    assign sat_val = (div_quo > RESULT_MAX) ? RESULT_MAX :
                     (div_quo < RESULT_MIN) ? RESULT_MIN : div_quo;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            run_q <= 1'b0;
            cfg_timing_q <= CFG_TIMING_RST;
            cfg_bridge_q <= CFG_BRIDGE_RST;
        end else begin
            if (wr_en && paddr == ADDR_CTRL) begin
                run_q <= pwdata[CTRL_RUN_BIT];
            end else if (state_q == SDSEQ_DONE && single_conv) begin
                run_q <= 1'b0;
            end
            if (wr_en && paddr == ADDR_CFG_TIMING) begin
                cfg_timing_q <= pwdata;
            end
            if (wr_en && paddr == ADDR_CFG_BRIDGE) begin
                cfg_bridge_q <= pwdata;
            end
        end
    end

    // Result word: one step is 10 nV/V of bridge ratio
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bridge_result_word_q <= 24'h00_0000;
            ready_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            if (div_done) begin
                bridge_result_word_q <= sat_val[23:0];
                ready_q <= 1'b1;
            end else if (rd_result) begin
                ready_q <= 1'b0;
            end
            if (state_q == SDSEQ_DISCH && disch_limit && !done_lvl) begin
                ovf_q <= 1'b1;
            end else if (seq_start) begin
                ovf_q <= 1'b0;
            end
        end
    end

endmodule : sdseq_top

//--- rtl/sdseq_pkg.sv
package sdseq_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned UNIT_TIME_NS = 2000;
    localparam int unsigned SLOW_OSC_HZ = 10000;
    localparam int unsigned PAIR2_TIME_US = 200;
    localparam int unsigned PAIR3_TIME_US = 300;
    localparam int unsigned UNIT_CYC = (UNIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PAIR2_CYC = (PAIR2_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PAIR3_CYC = (PAIR3_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECHARGE_PCT = 30;

    // Register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG_TIMING = 8'h08;
    localparam logic [7:0] ADDR_CFG_BRIDGE = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_RESULT = 8'h14;
    localparam logic [7:0] ADDR_COMP = 8'h18;

    // Field positions
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned SINGLE_BIT = 2;
    localparam int unsigned INTERVAL_LSB = 4;
    localparam int unsigned INTERVAL_MSB = 13;
    localparam int unsigned AVG_LSB = 16;
    localparam int unsigned AVG_MSB = 31;
    localparam int unsigned BRIDGE_LSB = 0;
    localparam int unsigned BRIDGE_MSB = 1;
    localparam int unsigned TRIM_LSB = 4;
    localparam int unsigned TRIM_MSB = 9;
    localparam int unsigned STRETCH_LSB = 12;
    localparam int unsigned STRETCH_MSB = 13;
    localparam int unsigned CLKSRC_BIT = 14;
    localparam int unsigned ST_OVF_BIT = 0;
    localparam int unsigned ST_READY_BIT = 1;
    localparam int unsigned ST_BUSY_BIT = 2;

    // Reset values
    localparam logic [31:0] CFG_TIMING_RST = 32'h0002_0500;
    localparam logic [31:0] CFG_BRIDGE_RST = 32'h0000_0041;

    // Bridge topology codes
    localparam logic [1:0] BRIDGE_HALF = 2'h0;
    localparam logic [1:0] BRIDGE_FULL = 2'h1;
    localparam logic [1:0] BRIDGE_QUATTRO = 2'h3;
    localparam logic [3:0] CPS_HALF = 4'h2;
    localparam logic [3:0] CPS_FULL = 4'h4;
    localparam logic [3:0] CPS_QUATTRO = 4'h8;

    // Result limits
    localparam logic signed [31:0] RESULT_MAX = 32'sh007F_FFFF;
    localparam logic signed [31:0] RESULT_MIN = -32'sh007F_FFFF;

    typedef enum logic [2:0] {
        SDSEQ_IDLE = 3'b000,
        SDSEQ_DISCH = 3'b001,
        SDSEQ_GAP = 3'b010,
        SDSEQ_DIV = 3'b011,
        SDSEQ_DONE = 3'b100
    } sdseq_state_t;

    typedef enum logic [1:0] {
        SDSEQ_PH_DUMMY = 2'b00,
        SDSEQ_PH_COMP = 2'b01,
        SDSEQ_PH_SAMPLE = 2'b10
    } sdseq_phase_t;

endpackage : sdseq_pkg

//--- rtl/sdseq_divider.sv
`timescale 1ns/100ps
module sdseq_divider
    import sdseq_pkg::*;
#(
    parameter int unsigned DW = 32,
    parameter int unsigned VW = 16
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic signed [DW-1:0] dividend,
    input wire logic [VW-1:0] divisor,
    output logic done,
    output logic signed [DW-1:0] quotient
);

    logic [DW-1:0] mag_q;
    logic [DW-1:0] quo_q;
    logic [DW:0] rem_q;
    logic [VW-1:0] div_q;
    logic neg_q;
    logic busy_q;
    logic [5:0] cnt_q;
    logic done_q;
    logic [DW:0] rem_sh;
    logic [DW:0] rem_sub;
    logic fits;

    assign rem_sh = {rem_q[DW-1:0], mag_q[DW-1]};
    assign rem_sub = rem_sh - {{(DW+1-VW){1'b0}}, div_q};
    assign fits = !rem_sub[DW];
    assign done = done_q;
    assign quotient = neg_q ? -$signed(quo_q) : $signed(quo_q);

    // Restoring division on magnitudes, one bit a cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mag_q <= '0;
            quo_q <= '0;
            rem_q <= '0;
            div_q <= '0;
            neg_q <= 1'b0;
            busy_q <= 1'b0;
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                mag_q <= dividend[DW-1] ? DW'(-dividend) : DW'(dividend);
                neg_q <= dividend[DW-1];
                div_q <= (divisor == '0) ? VW'(1) : divisor;
                rem_q <= '0;
                quo_q <= '0;
                cnt_q <= 6'(DW);
                busy_q <= 1'b1;
            end else if (busy_q) begin
                mag_q <= {mag_q[DW-2:0], 1'b0};
                rem_q <= fits ? rem_sub : rem_sh;
                quo_q <= {quo_q[DW-2:0], fits};
                cnt_q <= cnt_q - 6'h01;
                if (cnt_q == 6'h01) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

endmodule : sdseq_divider

//--- tb/sdseq_props.sv
`timescale 1ns/100ps
module sdseq_props
    import sdseq_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic discharge_done_pin,
    input wire logic slow_osc_pin,
    input wire logic discharge_en,
    input wire logic recharge_en,
    input wire logic [2:0] gauge_sel,
    input wire logic fast_osc_en,
    input wire logic rc_osc_sel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire logic acc = psel && penable;
    wire logic mapped = paddr inside {ADDR_CTRL, ADDR_CFG_TIMING, ADDR_CFG_BRIDGE,
        ADDR_STATUS, ADDR_RESULT, ADDR_COMP};
    ////////////////////////////////////////////////////////////////////////////
    property p_rdy; acc |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready in access");
    property p_err_map; acc && !mapped |-> pslverr; endproperty
    a_err_map: assert property (p_err_map) else $error("unmapped not refused");
    property p_err_ok; !(acc && !mapped) |-> !pslverr; endproperty
    a_err_ok: assert property (p_err_ok) else $error("spurious slave error");
    property p_excl; !(discharge_en && recharge_en); endproperty
    a_excl: assert property (p_excl) else $error("discharge and recharge overlap");
    property p_dis_end; $rose(discharge_done_pin) && discharge_en |-> ##[1:4] !discharge_en;
    endproperty
    a_dis_end: assert property (p_dis_end) else $error("discharge not ended");
    property p_rch; $rose(recharge_en) |-> $past(discharge_en); endproperty
    a_rch: assert property (p_rch) else $error("recharge without discharge");
    property p_osc; discharge_en |-> fast_osc_en; endproperty
    a_osc: assert property (p_osc) else $error("fast clock off in discharge");
    property p_rc_src;
        $changed(rc_osc_sel) |-> $past(acc && pwrite && paddr == ADDR_CFG_BRIDGE);
    endproperty
    a_rc_src: assert property (p_rc_src) else $error("clock select changed alone");
endmodule : sdseq_props

bind sdseq_top sdseq_props i_sdseq_props(.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .discharge_done_pin(discharge_done_pin),
    .slow_osc_pin(slow_osc_pin), .discharge_en(discharge_en), .recharge_en(recharge_en),
    .gauge_sel(gauge_sel), .fast_osc_en(fast_osc_en), .rc_osc_sel(rc_osc_sel));

//--- tb/sdseq_bridge.sv
`timescale 1ns/100ps
module sdseq_bridge (
    input wire logic core_clk,
    input wire logic discharge_en,
    input wire logic [2:0] gauge_sel,
    input wire integer base_cyc,
    output logic discharge_done_pin
);
    int cnt = 0;
    // Discharge time grows with gauge index
    always_ff @(posedge core_clk) begin
        cnt <= discharge_en ? cnt + 1 : 0;
    end
    assign discharge_done_pin = discharge_en && (cnt >= base_cyc + 4 * int'(gauge_sel));
endmodule : sdseq_bridge

//--- tb/sdseq_tb_top.sv
`timescale 1ns/100ps
module sdseq_tb_top
    import sdseq_pkg::*;
;
    logic core_clk = 0;
    logic reset = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, done_pin, dis_en, rch_en, fosc, rc_sel;
    logic slow_osc = 0;
    logic slow_on = 0;
    logic de_q = 0;
    logic [2:0] gsel;
    int base_cyc = 100;
    int bad_count = 0, n_compared = 0, n_dis = 0, cyc = 0, d0 = 0;
    int ts[8];
    localparam int PAIR2_TB = 20;
    localparam int PAIR3_TB = 30;
    int topo_l[4] = '{0, 1, 3, 1};
    int avg_l[4] = '{2, 1, 2, 4};

    always #25 core_clk = ~core_clk;
    always #50000 if (slow_on) slow_osc <= ~slow_osc;

    sdseq_top #(.PAIR2_CYCLES(PAIR2_TB), .PAIR3_CYCLES(PAIR3_TB)) i_sdseq_top(
        .core_clk(core_clk),
        .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .discharge_done_pin(done_pin), .slow_osc_pin(slow_osc), .discharge_en(dis_en),
        .recharge_en(rch_en), .gauge_sel(gsel), .fast_osc_en(fosc), .rc_osc_sel(rc_sel));
    sdseq_bridge i_sdseq_bridge(.core_clk(core_clk), .discharge_en(dis_en),
        .gauge_sel(gsel), .base_cyc(base_cyc), .discharge_done_pin(done_pin));

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        de_q <= dis_en;
        if (dis_en && !de_q) begin
            n_dis <= n_dis + 1;
            if (n_dis - d0 < 8) ts[n_dis - d0] <= cyc;
        end
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            bad_count++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic run_seq(input int topo, input int avg, input int str, input int iv,
                           input bit ck_res);
        int i, cps, per, exp;
        cps = topo == 0 ? 2 : (topo == 3 ? 8 : 4);
        apb(1, ADDR_CFG_BRIDGE, 32'(topo) | 32'(2 * avg) << 4 | 32'(str) << 12
            | 32'(str != 0) << 14);
        apb(1, ADDR_CFG_TIMING, 32'(avg) << 16 | 32'(iv) << 4 | 32'h4);
        d0 = n_dis;
        apb(1, ADDR_CTRL, 32'h1);
        for (i = 0; i < 20000; i++) begin
            apb(0, ADDR_STATUS, 32'h0);
            if (rd[ST_READY_BIT] === 1'b1) break;
        end
        if (i == 20000) begin
            bad_count++;
            results();
        end
        chk("discharges", n_dis - d0, 2 + avg * cps);
        exp = str == 0 ? iv * 40 : iv * 2000;
        per = ts[2] - ts[1];
        if (str != 0 && per >= exp - 3 && per <= exp + 3) per = exp;
        chk("period", per, exp);
        if (str > 1) chk("pair", ts[3] - ts[2], str == 3 ? PAIR3_TB : PAIR2_TB);
        apb(0, ADDR_RESULT, 32'h0);
        if (ck_res) chk("result", rd, -(cps / 2) * 4);
        apb(0, ADDR_COMP, 32'h0);
        if (ck_res) chk("comp", rd, base_cyc + 2);
        apb(0, ADDR_STATUS, 32'h0);
        chk("ready_clr", rd[ST_READY_BIT], 1'b0);
        $display("test topo %0d avg %0d stretch %0d done", topo, avg, str);
    endtask : run_seq

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        apb(0, ADDR_CFG_TIMING, 32'h0);
        chk("timing_rst", rd, CFG_TIMING_RST);
        apb(0, ADDR_CFG_BRIDGE, 32'h0);
        chk("bridge_rst", rd, CFG_BRIDGE_RST);
        apb(1, ADDR_CFG_TIMING, 32'hFFFF_3FF4);
        apb(0, ADDR_CFG_TIMING, 32'h0);
        chk("interval_rw", rd, 32'hFFFF_3FF4);
        apb(1, 8'h04, 32'hFFFF_FFFF);
        chk("unmapped_werr", err, 1'b1);
        apb(0, 8'h04, 32'h0);
        chk("unmapped_rd", rd, 32'h0);
        apb(1, ADDR_RESULT, 32'h1234_5678);
        apb(0, ADDR_RESULT, 32'h0);
        chk("result_ro", rd, 32'h0);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            run_seq(topo_l[k], avg_l[k], 0, 10, 1'b1);
        end
        base_cyc = 320;
        run_seq(1, 2, 0, 10, 1'b0);
        chk("overflow", rd[ST_OVF_BIT], 1'b1);
        base_cyc = 100;
        run_seq(1, 2, 0, 10, 1'b1);
        chk("overflow_clr", rd[ST_OVF_BIT], 1'b0);
        slow_on = 1'b1;
        run_seq(0, 1, 1, 2, 1'b1);
        chk("rc_sel", rc_sel, 1'b1);
        base_cyc = 4;
        run_seq(0, 1, 2, 2, 1'b1);
        slow_on = 1'b0;
        results();
    end
endmodule : sdseq_tb_top
